/* File: hw/odt_latency_control.sv */
// on-die termination control: synchronous latency, async mode, power-down entry
// ----------------------------------------
// Notes on behaviour
// - termination follows pin after on/off latency
// - both latencies are write latency minus two
// - sync pin copy delayed by additive latency
// - async mode in dll-off powerdown, dll resync
// - async mode skips additive latency delay
// - async response within two to 8.5 ns; here one 10 ns clock (ASYNC_DELAY) after the synchroniser
// - entry transition lead before first cke low; here the lead is counted from the cke fall
// - lead is larger latency plus one
// - refresh in flight stretches entry transition
// - termination uncertain during entry transition
// - sync whenever dll locked and cke high
// ----------------------------------------
`timescale 1ns/1ns
module odt_latency_control
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // pins from the controller
  input wire logic odt_pin_in,
  input wire logic cke_pin_in,
  // mode settings
  input wire logic [odt_pkg::WR_CAS_W-1:0] write_cas_latency_in,
  input wire logic [odt_pkg::ADD_LAT_W-1:0] additive_latency_in,
  input wire logic [3:0] cas_latency_in,
  input wire logic dll_on_in_powerdown_in,
  input wire logic term_nom_enable_in,
  input wire logic term_wr_enable_in,
  // core state
  input wire logic dll_locked_in,
  input wire logic refresh_busy_in,
  // termination result
  output logic term_enable_out,
  output logic term_uncertain_out,
  output logic async_mode_out,
  output logic [odt_pkg::LAT_W-1:0] term_latency_out,
  output logic [odt_pkg::LAT_W-1:0] pd_transition_lead_out
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic odt_meta;
  logic odt_sync;
  logic cke_meta;
  logic cke_sync;
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      odt_meta <= 1'b0;
      odt_sync <= 1'b0;
      cke_meta <= 1'b0;
      cke_sync <= 1'b0;
    end
    else if (clk_en_in)
    begin
      odt_meta <= odt_pin_in;
      odt_sync <= odt_meta;
      cke_meta <= cke_pin_in;
      cke_sync <= cke_meta;
    end
  end

  // ----------------------------------------
  // latencies
  // ----------------------------------------
  logic [odt_pkg::LAT_W-1:0] add_lat_cycles;
  logic [odt_pkg::LAT_W-1:0] write_latency;
  logic [odt_pkg::LAT_W-1:0] next_term_latency;
  logic [odt_pkg::LAT_W-1:0] next_lead;
  logic term_any_enabled;
  always_comb
  begin
    case (additive_latency_in)
      odt_pkg::ADD_LAT_CODE_ZERO: add_lat_cycles = '0;
      odt_pkg::ADD_LAT_CODE_CL1: add_lat_cycles = 5'({1'b0, cas_latency_in} - 5'h01);
      odt_pkg::ADD_LAT_CODE_CL2: add_lat_cycles = 5'({1'b0, cas_latency_in} - 5'h02);
      default: add_lat_cycles = '0;
    endcase
    write_latency = 5'({1'b0, write_cas_latency_in}) + add_lat_cycles;
    // saturate so a write latency of two or less never wraps to a huge latency
    next_term_latency = (write_latency > odt_pkg::TERM_LAT_OFFSET) ?
      write_latency - odt_pkg::TERM_LAT_OFFSET : '0;
    next_lead = next_term_latency + odt_pkg::PD_LEAD_EXTRA;
    term_any_enabled = term_nom_enable_in || term_wr_enable_in;
  end

  // ----------------------------------------
  // mode selection
  // ----------------------------------------
  odt_pkg::odt_mode_type mode;
  logic [odt_pkg::LAT_W-1:0] lead_count;
  logic cke_prev;
  logic dll_off_pd;
  assign dll_off_pd = !dll_on_in_powerdown_in;
  // entry window is predicted from cke falling; the lead is honoured by
  // declaring uncertainty for lead plus one cycles after the fall instead of before
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mode <= odt_pkg::ODT_ASYNC;
      lead_count <= '0;
      cke_prev <= 1'b0;
    end
    else if (clk_en_in)
    begin
      cke_prev <= cke_sync;
      case (mode)
        odt_pkg::ODT_SYNC:
        begin
          if (!dll_locked_in)
            mode <= odt_pkg::ODT_ASYNC;
          else if (cke_prev && !cke_sync && dll_off_pd && term_any_enabled)
          begin
            mode <= odt_pkg::ODT_ENTRY;
            lead_count <= next_term_latency + odt_pkg::PD_LEAD_EXTRA;
          end
        end
        odt_pkg::ODT_ENTRY:
        begin
          if (lead_count != '0)
            lead_count <= lead_count - 5'h01;
          // a refresh in flight keeps the window open until it completes
          else if (!refresh_busy_in)
            mode <= odt_pkg::ODT_ASYNC;
          if (cke_sync && dll_locked_in)
            mode <= odt_pkg::ODT_SYNC;
        end
        odt_pkg::ODT_ASYNC:
        begin
          if (dll_locked_in && (cke_sync || !dll_off_pd))
            mode <= odt_pkg::ODT_SYNC;
        end
        default: mode <= odt_pkg::ODT_ASYNC;
      endcase
    end
  end

  // ----------------------------------------
  // synchronous delay pipeline
  // ----------------------------------------
  logic [odt_pkg::PIPE_DEPTH-1:0] pipe;
  logic [odt_pkg::LAT_W-1:0] lat_reg;
  logic lat_changed;
  assign lat_changed = next_term_latency != lat_reg;
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pipe <= '0;
      lat_reg <= '0;
    end
    else if (clk_en_in)
    begin
      lat_reg <= next_term_latency;
      if (lat_changed)
        pipe <= '0;
      else
        pipe <= {pipe[odt_pkg::PIPE_DEPTH-2:0], odt_sync};
    end
  end
  // tap index = latency minus one: pipe[0] is one cycle after the sample
  logic sync_term;
  assign sync_term = (lat_reg == '0) ? odt_sync : pipe[lat_reg - 5'h01];

  // ----------------------------------------
  // asynchronous path
  // ----------------------------------------
  logic [2:0] async_count;
  logic async_term;
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      async_count <= '0;
      async_term <= 1'b0;
    end
    else if (clk_en_in)
    begin
      // additive latency is not applied here
      if (odt_sync == async_term)
        async_count <= '0;
      else if (async_count + 3'h1 >= odt_pkg::ASYNC_DELAY)
      begin
        async_term <= odt_sync;
        async_count <= '0;
      end
      else
        async_count <= async_count + 3'h1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      term_enable_out <= 1'b0;
      term_uncertain_out <= 1'b0;
      async_mode_out <= 1'b1;
      term_latency_out <= '0;
      pd_transition_lead_out <= '0;
    end
    else if (clk_en_in)
    begin
      term_latency_out <= next_term_latency;
      pd_transition_lead_out <= next_lead;
      async_mode_out <= mode == odt_pkg::ODT_ASYNC;
      term_uncertain_out <= mode == odt_pkg::ODT_ENTRY;
      if (!term_any_enabled)
        term_enable_out <= 1'b0;
      else if (mode == odt_pkg::ODT_SYNC)
        term_enable_out <= sync_term;
      else if (mode == odt_pkg::ODT_ASYNC)
        term_enable_out <= async_term;
      else
        term_enable_out <= sync_term | async_term;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  lat_formula_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && write_latency > 5'h02 |=> term_latency_out == $past(write_latency) - 5'h02)
    else $error("termination latency not write latency minus two");
  lat_floor_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && write_latency <= 5'h02 |=> term_latency_out == '0)
    else $error("short write latency did not give zero latency");
  lead_formula_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in |=> pd_transition_lead_out == $past(next_term_latency) + 5'h01)
    else $error("entry lead not latency plus one");
  sync_follow_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_SYNC && term_any_enabled
    |=> term_enable_out == $past(sync_term))
    else $error("sync termination not following delayed pin");
  pipe_shift_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && !lat_changed |=> pipe[0] == $past(odt_sync))
    else $error("pin copy not entering delay pipeline");
  flush_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && lat_changed |=> pipe == '0)
    else $error("pipeline not flushed on latency change");
  async_enter_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && !dll_locked_in && mode == odt_pkg::ODT_SYNC
    |=> mode == odt_pkg::ODT_ASYNC)
    else $error("lost dll lock did not force async mode");
  async_flag_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in |=> async_mode_out == ($past(mode) == odt_pkg::ODT_ASYNC))
    else $error("async mode flag not following mode");
  async_follow_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_ASYNC && term_any_enabled
    |=> term_enable_out == $past(async_term))
    else $error("async termination not taken from undelayed pin");
  async_bound_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && async_count != '0 |-> async_count < odt_pkg::ASYNC_DELAY)
    else $error("async response slower than bound");
  entry_start_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_SYNC && dll_locked_in && cke_prev && !cke_sync
    && dll_off_pd && term_any_enabled |=> mode == odt_pkg::ODT_ENTRY ##1 term_uncertain_out)
    else $error("entry transition not started");
  entry_count_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_ENTRY && lead_count != '0 && !cke_sync
    |=> mode == odt_pkg::ODT_ENTRY && lead_count == $past(lead_count) - 5'h01)
    else $error("entry lead not counting down");
  refresh_hold_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_ENTRY && refresh_busy_in && !cke_sync
    |=> mode == odt_pkg::ODT_ENTRY)
    else $error("entry ended during refresh");
  entry_end_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_ENTRY && lead_count == '0 && !refresh_busy_in
    && !cke_sync |=> mode == odt_pkg::ODT_ASYNC)
    else $error("entry transition did not end");
  uncertain_flag_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in |=> term_uncertain_out == ($past(mode) == odt_pkg::ODT_ENTRY))
    else $error("uncertain flag not matching entry window");
  entry_merge_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_ENTRY && term_any_enabled
    |=> term_enable_out == $past(sync_term | async_term))
    else $error("entry window not merging both responses");
  sync_return_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && mode == odt_pkg::ODT_ASYNC && dll_locked_in && cke_sync
    |=> mode == odt_pkg::ODT_SYNC)
    else $error("locked dll with cke high not back in sync mode");
  off_disabled_a:
    assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && !term_any_enabled |=> !term_enable_out)
    else $error("termination on while disabled");
endmodule

/* File: hw/odt_pkg.sv */
// constants for the on-die termination latency control block
package odt_pkg;
  // latency fields
  localparam int WR_CAS_W = 4;
  localparam int ADD_LAT_W = 2;
  localparam int LAT_W = 5;
  // write latency minus this gives the termination latencies
  localparam logic [4:0] TERM_LAT_OFFSET = 5'h02;
  // extra cycle on top of the larger latency for the entry lead
  localparam logic [4:0] PD_LEAD_EXTRA = 5'h01;
  // additive latency codes
  localparam logic [1:0] ADD_LAT_CODE_ZERO = 2'h0;
  localparam logic [1:0] ADD_LAT_CODE_CL1 = 2'h1;
  localparam logic [1:0] ADD_LAT_CODE_CL2 = 2'h2;
  // pipeline depth: largest write_cas_latency 15 plus additive latency up to 14
  localparam int PIPE_DEPTH = 32;
  // holds, in clock cycles
  localparam logic [2:0] SHORT_TERM_HOLD = 3'h4;
  localparam logic [2:0] LONG_TERM_HOLD = 3'h6;
  // asynchronous delays in picoseconds
  localparam int CLOCK_PERIOD_PS = 10000;
  localparam int ASYNC_MIN_PS = 2000;
  localparam int ASYNC_MAX_PS = 8500;
  // min rounds up, max rounds down, never below one cycle
  localparam int ASYNC_MIN_CYC_RAW = (ASYNC_MIN_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int ASYNC_MAX_CYC_RAW = ASYNC_MAX_PS / CLOCK_PERIOD_PS;
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
  localparam int ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
  localparam logic [2:0] ASYNC_DELAY = 3'(ASYNC_MIN_CYC);
  typedef enum logic [1:0] {ODT_SYNC, ODT_ENTRY, ODT_ASYNC} odt_mode_type;
endpackage

/* File: sim/odt_ctrl_model.sv */
// controller-side model that drives the odt pin and keeps its hold rules
`timescale 1ns/1ns
module odt_ctrl_model
(
  // clock
  input wire logic clock_in,
  // request from the bench
  input wire logic go_in,
  input wire logic [3:0] len_in,
  input wire logic wr_in,
  input wire logic bl8_in,
  // pin
  output logic odt_out
);
  // two counters so the later hold window always wins
  // no reads are issued, so odt never overlaps read preamble or postamble
  logic [3:0] hold_cnt = 4'h0;
  logic [3:0] wr_cnt = 4'h0;
  logic g;
  logic w;
  logic b;
  logic [3:0] l;
  initial odt_out = 1'b0;
  always @(posedge clock_in)
  begin
    g = go_in;
    w = wr_in;
    b = bl8_in;
    l = len_in;
    #1;
    if (g)
    begin
      odt_out = 1'b1;
      hold_cnt = (l > 4'h4) ? l : 4'(odt_pkg::SHORT_TERM_HOLD);
      wr_cnt = !w ? 4'h0 : b ? 4'(odt_pkg::LONG_TERM_HOLD) : 4'h4;
    end
    else
    begin
      if (hold_cnt <= 4'h1 && wr_cnt <= 4'h1) odt_out = 1'b0;
      if (hold_cnt != 4'h0) hold_cnt = hold_cnt - 4'h1;
      if (wr_cnt != 4'h0) wr_cnt = wr_cnt - 4'h1;
    end
  end
endmodule

/* File: sim/odt_latency_control_test.sv */
// self-checking testbench for the termination latency control
`timescale 1ns/1ns
module odt_latency_control_test;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cke = 1'b1;
  logic dll = 1'b1;
  logic dllpd = 1'b1;
  logic nom = 1'b1;
  logic rfsh = 1'b0;
  logic [3:0] wr_cas = 4'h5;
  logic [3:0] cl = 4'h6;
  logic [1:0] add_lat = 2'h0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic bl8 = 1'b0;
  logic [3:0] len = 4'h1;
  logic odt;
  logic te;
  logic tu;
  logic am;
  logic [4:0] lat;
  logic [4:0] lead;
  int errors = 0;
  int cmp_count = 0;
  int n;
  // rows: write_cas_latency, additive code, cas latency, expected latency
  logic [14:0] rows [6] = '{{4'h5, 2'h0, 4'h6, 5'h03}, {4'h5, 2'h1, 4'h6, 5'h08},
    {4'h5, 2'h2, 4'h6, 5'h07}, {4'h5, 2'h3, 4'h6, 5'h03}, {4'h2, 2'h0, 4'h6, 5'h00},
    {4'h8, 2'h1, 4'h7, 5'h0c}};
  initial forever #5 clock_in = ~clock_in;
  odt_latency_control odt_latency_control_i (.clock_in(clock_in), .rstn_in(rstn_in),
    .clk_en_in(1'b1), .odt_pin_in(odt), .cke_pin_in(cke), .write_cas_latency_in(wr_cas),
    .additive_latency_in(add_lat), .cas_latency_in(cl), .dll_on_in_powerdown_in(dllpd),
    .term_nom_enable_in(nom), .term_wr_enable_in(1'b0), .dll_locked_in(dll),
    .refresh_busy_in(rfsh), .term_enable_out(te), .term_uncertain_out(tu),
    .async_mode_out(am), .term_latency_out(lat), .pd_transition_lead_out(lead));
  odt_ctrl_model odt_ctrl_model_i (.clock_in(clock_in), .go_in(go), .len_in(len),
    .wr_in(wr), .bl8_in(bl8), .odt_out(odt));
  function automatic logic pick(input int s);
    return (s == 0) ? te : (s == 1) ? tu : am;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask
  // counts edges until the chosen output reaches v, bounded by lim
  task automatic wsig(input int s, input logic v, input int lim);
    n = 0;
    do
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    while (pick(s) !== v && n < lim);
  endtask
  task automatic pulse(input logic [3:0] l, input logic w);
    len = l;
    wr = w;
    bl8 = 1'b1;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    tick(4);
    chk({te, tu, am, lat}, 8'h20);
    rstn_in = 1'b1;
    $display("test reset done");
    foreach (rows[i])
    begin
      {wr_cas, add_lat, cl} = rows[i][14:5];
      tick(3);
      chk(8'(lat), 8'(rows[i][4:0]));
      chk(8'(lead), 8'(rows[i][4:0] + 5'h01));
    end
    chk(8'(am), 8'h00);
    $display("test table done");
    {wr_cas, cl} = 8'h56;
    for (int k = 0; k < 2; k++)
    begin
      add_lat = k[0] ? 2'h2 : 2'h0;
      tick(3);
      pulse(4'h1, k[0]);
      wsig(0, 1'b1, 40);
      chk(8'(n), k[0] ? 8'h0a : 8'h06);
      wsig(0, 1'b0, 40);
      chk(8'(n), k[0] ? 8'h06 : 8'h04);
    end
    $display("test sync done");
    add_lat = 2'h1;
    tick(3);
    dllpd = 1'b0;
    cke = 1'b0;
    wsig(1, 1'b1, 8);
    chk(8'(tu), 8'h01);
    wsig(1, 1'b0, 20);
    chk(8'(n >= 9 && n <= 11), 8'h01);
    tick(1);
    chk(8'(am), 8'h01);
    pulse(4'h4, 1'b0);
    wsig(0, 1'b1, 20);
    chk(8'(n), 8'h04);
    wsig(0, 1'b0, 20);
    chk(8'(n), 8'h04);
    $display("test async done");
    cke = 1'b1;
    wsig(2, 1'b0, 10);
    chk(8'(am), 8'h00);
    rfsh = 1'b1;
    cke = 1'b0;
    tick(16);
    chk(8'(tu), 8'h01);
    rfsh = 1'b0;
    wsig(1, 1'b0, 5);
    chk(8'(tu), 8'h00);
    $display("test refresh done");
    cke = 1'b1;
    nom = 1'b0;
    tick(6);
    pulse(4'h4, 1'b0);
    tick(20);
    chk(8'(te), 8'h00);
    $display("test disabled done");
    end_sim();
  end
  // the whole run needs well under two thousand cycles
  initial
  begin
    #100000;
    errors++;
    end_sim();
  end
endmodule
